// [pbc_defines.svh]
// Timing and reset constants for the pushbutton on/off latch
`ifndef PBC_DEFINES_SVH
`define PBC_DEFINES_SVH

// ==========================================================
// Clock and time base
`define PBC_CLK_PERIOD_NS     5
`define PBC_TICK_NS           1000000
`define PBC_TICK_CYCLES       (`PBC_TICK_NS / `PBC_CLK_PERIOD_NS)

// ==========================================================
// Durations in milliseconds
`define PBC_DEBOUNCE_SHORT_MS 50
`define PBC_DEBOUNCE_LONG_MS  2000
`define PBC_SHUTOFF_SHORT_MS  8000
`define PBC_SHUTOFF_LONG_MS   16000
`define PBC_IRQ_MS            32
`define PBC_IRQ_EXT_MS        128

// ==========================================================
// Widths and reset values
`define PBC_TICK_W            32
`define PBC_HOLD_W            16
`define PBC_IRQ_W             8
`define PBC_SYNC_IDLE         2'h3

`endif

// [pbc_pkg.sv]
// Types shared by the pushbutton on/off latch
package pbc_pkg;

	// ==========================================================
	// Closure tracking states
	typedef enum logic [1:0] {
		PBC_IDLE,
		PBC_DEBOUNCE,
		PBC_HELD,
		PBC_WAIT_RELEASE
	} pbc_state_t;

	// ==========================================================
	// Millisecond timers
	typedef struct packed {
		logic [15:0] hold;
		logic [7:0]  irq;
	} pbc_timers_t;

endpackage : pbc_pkg

// [pbc_sync2.sv]
// Two-flop synchroniser for the button and clear pins
`timescale 1ns/10ps
`include "pbc_defines.svh"

module pbc_sync2 (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Pins in, synchronised levels out
	input  wire logic [1:0] pin_in,
	output logic      [1:0] pin_sync
);

	// ==========================================================
	// Stages
	logic [1:0] stage1;
	logic [1:0] next_stage1;
	logic [1:0] next_pin_sync;

	always_comb
	begin
		next_stage1   = pin_in;
		next_pin_sync = stage1;
	end

	// Idle high so a reset never looks like a closure
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			stage1   <= `PBC_SYNC_IDLE;
			pin_sync <= `PBC_SYNC_IDLE;
		end
		else
		begin
			stage1   <= next_stage1;
			pin_sync <= next_pin_sync;
		end
	end

endmodule : pbc_sync2

// [pbc_latch.sv]
// Pushbutton on/off latch with debounce, shutoff and one-shot interrupt
`timescale 1ns/10ps
`include "pbc_defines.svh"

module pbc_latch
	import pbc_pkg::*;
#(
	parameter bit          SHUTDOWN_VARIANT = 1'b1,
	parameter bit          LONG_DEBOUNCE    = 1'b0,
	parameter bit          LONG_SHUTOFF     = 1'b0,
	parameter int unsigned TICK_CYCLES      = `PBC_TICK_CYCLES
) (
	// Clock and lockout reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Pins from the switch and the system
	input  wire logic button_in_n,
	input  wire logic force_off_n,
	// Latched power output, push-pull
	output logic      power_out,
	// Open-drain interrupt, active low
	output logic      irq_n_out,
	output logic      irq_oe
);

	// ==========================================================
	// Durations
	localparam logic [15:0] DB_MS  = LONG_DEBOUNCE ? 16'(`PBC_DEBOUNCE_LONG_MS)
	                                               : 16'(`PBC_DEBOUNCE_SHORT_MS);
	localparam logic [15:0] SO_MS  = LONG_SHUTOFF ? 16'(`PBC_SHUTOFF_LONG_MS)
	                                              : 16'(`PBC_SHUTOFF_SHORT_MS);
	localparam logic [7:0]  IRQ_MS = 8'(`PBC_IRQ_MS);
	localparam logic [7:0]  EXT_MS = 8'(`PBC_IRQ_EXT_MS);
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

	function automatic logic pbc_reached(input logic [15:0] cnt, input logic tk,
	                                     input logic [15:0] target);
		pbc_reached = tk && ((cnt + 16'h0001) == target);
	endfunction : pbc_reached

	// ==========================================================
	// Input synchronisation
	logic [1:0] pin_sync;
	logic       btn_low;
	logic       clr_act;

	pbc_sync2 u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.pin_in   ({button_in_n, force_off_n}),
		.pin_sync (pin_sync)
	);

	assign btn_low = !pin_sync[1];
	assign clr_act = !pin_sync[0];

	// ==========================================================
	// Millisecond time base
	// Free-running: first tick of a closure lands within 1 ms, well inside tolerance
	logic [31:0] tick_cnt;
	logic [31:0] next_tick_cnt;
	logic        tick;

	always_comb
	begin
		tick          = (tick_cnt == TICK_LAST);
		next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			tick_cnt <= 32'h0000_0000;
		else
			tick_cnt <= next_tick_cnt;
	end

	// ==========================================================
	// Closure tracking and outputs
	pbc_state_t  state;
	pbc_state_t  next_state;
	pbc_timers_t timers;
	pbc_timers_t next_timers;
	logic        next_power;
	logic [15:0] hold_step;

	always_comb
	begin
		next_state  = state;
		next_timers = timers;
		next_power  = power_out;
		hold_step   = tick ? timers.hold + 16'h0001 : timers.hold;
		if (tick && (timers.irq != '0))
			next_timers.irq = timers.irq - 8'h01;
		case (state)
			PBC_IDLE:
			begin
				if (btn_low)
				begin
					next_state       = PBC_DEBOUNCE;
					next_timers.hold = '0;
				end
			end
			PBC_DEBOUNCE:
			begin
				if (!btn_low)
					next_state = PBC_IDLE;
				else
				begin
					next_timers.hold = hold_step;
					if (pbc_reached(timers.hold, tick, DB_MS))
					begin
						next_state      = PBC_HELD;
						next_power      = 1'b1;
						next_timers.irq = IRQ_MS;
					end
				end
			end
			PBC_HELD:
			begin
				if (!btn_low)
					next_state = PBC_IDLE;
				else
				begin
					next_timers.hold = hold_step;
					if (pbc_reached(timers.hold, tick, SO_MS))
					begin
						next_state = PBC_WAIT_RELEASE;
						if (SHUTDOWN_VARIANT)
							next_power = 1'b0;
						else
							next_timers.irq = EXT_MS;
					end
				end
			end
			PBC_WAIT_RELEASE:
			begin
				if (!btn_low)
					next_state = PBC_IDLE;
			end
			default:
				next_state = PBC_IDLE;
		endcase
		// Clear beats a closure landing in the same cycle at power_out; that closure's interrupt pulse still starts
		if (clr_act)
			next_power = 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state     <= PBC_IDLE;
			timers    <= '0;
			power_out <= 1'b0;
			irq_n_out <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			timers    <= next_timers;
			power_out <= next_power;
			irq_n_out <= 1'b0;
		end
	end

	assign irq_oe = (timers.irq != '0);

	// ==========================================================
	// Checks
	clear_forces_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clr_act |=> !power_out)
		else $error("power stayed on under clear");

	lockout_quiet_a: assert property (@(posedge ref_clk)
		!rst_n |=> (!power_out && !irq_oe))
		else $error("outputs active after lockout reset");

	debounce_sets_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == PBC_DEBOUNCE && btn_low && !clr_act && pbc_reached(timers.hold, tick, DB_MS))
		|=> (power_out && irq_oe && timers.irq == IRQ_MS))
		else $error("debounced closure did not latch and interrupt");

	// Natural end of a running pulse is not the short closure's doing
	short_press_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == PBC_DEBOUNCE && !btn_low && !clr_act
			&& !(tick && timers.irq == 8'h01))
		|=> (state == PBC_IDLE && $stable(power_out) && $stable(irq_oe)))
		else $error("short closure changed outputs");

	irq_on_tick_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(irq_oe) |-> $past(tick))
		else $error("interrupt ended off the time base");

	debounce_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == PBC_DEBOUNCE && $past(state) == PBC_DEBOUNCE) |-> (timers.hold < DB_MS))
		else $error("debounce count ran past its limit");

	generate
		if (SHUTDOWN_VARIANT)
		begin : g_shutdown
			shutoff_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
				(state == PBC_HELD && btn_low && pbc_reached(timers.hold, tick, SO_MS))
				|=> (!power_out && state == PBC_WAIT_RELEASE))
				else $error("long closure did not release power");
		end
		else
		begin : g_irq_only
			power_kept_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
				(power_out && !clr_act) |=> power_out)
				else $error("power released without clear");

			ext_irq_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
				(state == PBC_HELD && btn_low && pbc_reached(timers.hold, tick, SO_MS))
				|=> (irq_oe && timers.irq == EXT_MS))
				else $error("extended interrupt did not start");
		end
	endgenerate

endmodule : pbc_latch

// [pbc_button_model.sv]
// Pushbutton switch and interrupt pull-up as seen by the processor
`timescale 1ns/10ps
module pbc_button_model (
	// Clock
	input  wire logic ref_clk,
	// Interrupt pin from the latch
	input  wire logic irq_n_out,
	input  wire logic irq_oe,
	// Switch contact and resolved interrupt line
	output logic      button_in_n,
	output wire logic irq_line
);
	// ==========================================
	// Pull-up holds the line high while nobody sinks it
	assign irq_line = irq_oe ? irq_n_out : 1'b1;
	initial button_in_n = 1'b1;
	// ==========================================
	// Contacts chatter before they settle closed
	task automatic press(input int bounces, input int hold);
		repeat (bounces)
		begin
			@(posedge ref_clk);
			button_in_n <= ~button_in_n;
		end
		@(posedge ref_clk);
		button_in_n <= 1'b0;
		repeat (hold) @(posedge ref_clk);
		button_in_n <= 1'b1;
	endtask : press
endmodule : pbc_button_model

// [pbc_latch_bench.sv]
// Self-checking bench for the pushbutton on/off latch
`timescale 1ns/10ps
`include "pbc_defines.svh"
module pbc_latch_bench;
	// ==========================================
	// Short tick keeps the long hold near 34k cycles
	localparam int TK = 4;
	localparam int DB = `PBC_DEBOUNCE_SHORT_MS * TK;
	localparam int DBL = `PBC_DEBOUNCE_LONG_MS * TK;
	localparam int SO = `PBC_SHUTOFF_SHORT_MS * TK;
	localparam int IQ = `PBC_IRQ_MS * TK;
	localparam int IX = `PBC_IRQ_EXT_MS * TK;
	logic            ref_clk;
	logic            rst_n;
	logic            force_off_n;
	logic            button_in_n;
	wire logic [2:0] pwr;
	wire logic [1:0] irq_n;
	wire logic [1:0] oe;
	wire logic       irq_n_c;
	wire logic       oe_c;
	wire logic [1:0] irq_line;
	int              n_errors = 0;
	int              comparisons = 0;
	int              w [2] = '{0, 0};
	int              run [2] = '{0, 0};
	int              exp_pwr [3];
	int              k;
	int              n;
	int              m;
	// ==========================================
	// Variant with shutoff, then interrupt-only variant
	pbc_latch #(.SHUTDOWN_VARIANT(1'b1), .TICK_CYCLES(TK)) dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .button_in_n(button_in_n), .force_off_n(force_off_n),
		.power_out(pwr[0]), .irq_n_out(irq_n[0]), .irq_oe(oe[0]));
	pbc_latch #(.SHUTDOWN_VARIANT(1'b0), .TICK_CYCLES(TK)) dut_b (.ref_clk(ref_clk),
		.rst_n(rst_n), .button_in_n(button_in_n), .force_off_n(force_off_n),
		.power_out(pwr[1]), .irq_n_out(irq_n[1]), .irq_oe(oe[1]));
	// Long debounce and long shutoff build of the shutdown variant
	pbc_latch #(.SHUTDOWN_VARIANT(1'b1), .LONG_DEBOUNCE(1'b1), .LONG_SHUTOFF(1'b1),
		.TICK_CYCLES(TK)) dut_c (.ref_clk(ref_clk), .rst_n(rst_n),
		.button_in_n(button_in_n), .force_off_n(force_off_n), .power_out(pwr[2]),
		.irq_n_out(irq_n_c), .irq_oe(oe_c));
	pbc_button_model btn (.ref_clk(ref_clk), .irq_n_out(irq_n[0]), .irq_oe(oe[0]),
		.button_in_n(button_in_n), .irq_line(irq_line[0]));
	pbc_button_model proc_b (.ref_clk(ref_clk), .irq_n_out(irq_n[1]), .irq_oe(oe[1]),
		.button_in_n(), .irq_line(irq_line[1]));
	// ==========================================
	// Width of the latest interrupt pulse, in cycles
	always @(posedge ref_clk)
		for (int i = 0; i < 2; i++)
			if (irq_line[i] === 1'b0)
				run[i] <= run[i] + 1;
			else if (run[i] != 0)
			begin
				w[i] <= run[i];
				run[i] <= 0;
			end
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic check_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_bit
	// Accepts twenty percent either side of nominal
	task automatic check_rng(input int got, input int nom);
		comparisons++;
		if (got < nom * 8 / 10 || got > nom * 12 / 10)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, nom);
		end
	endtask : check_rng
	task automatic check_pwr();
		for (int i = 0; i < 3; i++)
			check_bit(pwr[i], exp_pwr[i][0]);
	endtask : check_pwr
	task automatic wait_pwr(input int i, input logic lvl, output int c);
		c = 0;
		while (pwr[i] !== lvl && c < 2 * SO)
		begin
			@(negedge ref_clk);
			c++;
		end
	endtask : wait_pwr
	task automatic report_and_stop();
		$display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#(10 * SO);
		n_errors++;
		report_and_stop();
	end
	initial
	begin
		rst_n = 1'b0;
		force_off_n = 1'b1;
		exp_pwr = '{0, 0, 0};
		void'($urandom(92682));
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		check_pwr();
		check_bit(irq_line[0] & irq_line[1], 1'b1);
		$display("test reset done");
		btn.press($urandom % 4, DB / 2 + $urandom % 40);
		repeat (DB) @(negedge ref_clk);
		check_pwr();
		check_bit(1'(w[0] + w[1] + run[0] == 0), 1'b1);
		$display("test short done");
		fork
			btn.press($urandom % 4, DB * 2);
			wait_pwr(0, 1'b1, n);
		join
		@(negedge ref_clk);
		exp_pwr = '{1, 1, 0};
		check_rng(n, DB);
		check_pwr();
		check_rng(w[0], IQ);
		check_rng(w[1], IQ);
		$display("test latch done");
		@(posedge ref_clk);
		force_off_n <= 1'b0;
		wait_pwr(0, 1'b0, n);
		exp_pwr = '{0, 0, 0};
		check_bit(1'(n <= 4), 1'b1);
		check_pwr();
		@(posedge ref_clk);
		force_off_n <= 1'b1;
		$display("test clear done");
		fork
			btn.press(2, SO + 4 * IX);
			begin
				wait_pwr(0, 1'b1, n);
				wait_pwr(0, 1'b0, m);
			end
			begin
				wait_pwr(2, 1'b1, k);
				check_bit(oe_c ? irq_n_c : 1'b1, 1'b0);
			end
		join
		@(negedge ref_clk);
		exp_pwr = '{0, 1, 1};
		check_rng(n + m, SO);
		check_rng(k, DBL);
		check_pwr();
		check_rng(w[0], IQ);
		check_rng(w[1], IX);
		$display("test long hold done");
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		exp_pwr = '{0, 0, 0};
		check_pwr();
		$display("test mid reset done");
		report_and_stop();
	end
endmodule : pbc_latch_bench
